// File: hdl/cpc_pkg.sv
/*
 * Shared constants, field layouts, carrier structs and state enums for
 * the charger / power path controller. Assumes a single 25 MHz system
 * clock and comparator inputs supplied by the analog front end.
 */
// What this block does
// R1: rail under 2.5 V for 1 ms enters hiccup
// R2: hiccup: switches off 36 ms, retry 1 ms
// R3: buck charging only when rail exceeds battery
// R4: cycle needs power-good, enable, thermistor window
// R5: below trickle threshold, trickle linear charging
// R6: constant-current switching at selected current
// R7: at cv threshold enter constant-voltage phase
// R8: current below level 32 us, go linear
// R9: above recharge and at termination: stop
// R10: battery droop 100 us starts switching recharge
// R11: die hot reduces charge current
// R12: standby kills thermistor bias, status 011
// R13: threshold crossing pulses; outside window terminates
// R14: battery level sampled every 100 ms
// R15: enable defaults 0; rising edge starts cycle
// R16: host toggles enable after termination, delays
// R17: rail at floor reduces charge current
// R18: input lost runs boost from battery
// R19: boost steps up or bypasses; voltage select
// R20: rail reference follows higher connected load
// R21: overload 1.2 ms: off, flag, 36 ms, soft-start
// R22: five-bit load current limit field
// R23: input window 30 ms sets power-good
// R24: reset returns all registers to defaults
// R25: binary-encoded phase sequencer, synchronized comparators
// R26: interval counters restart when condition drops
package cpc_pkg;

	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned TMR_W           = 24;

	localparam int unsigned SCP_DETECT_NS   = 1_000_000;
	localparam int unsigned HICCUP_OFF_NS   = 36_000_000;
	localparam int unsigned RETRY_NS        = 1_000_000;
	localparam int unsigned PG_DGL_NS       = 30_000_000;
	localparam int unsigned TERM_DGL_NS     = 32_000;
	localparam int unsigned RECH_DGL_NS     = 100_000;
	localparam int unsigned BST_OL_NS       = 1_200_000;
	localparam int unsigned BST_OFF_NS      = 36_000_000;
	localparam int unsigned SOFTSTART_NS    = 200_000;
	localparam int unsigned ADC_PERIOD_NS   = 100_000_000;

	// least times round up, the retry window is a longest time and rounds down
	localparam int unsigned SCP_DETECT_CYC  = (SCP_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HICCUP_OFF_CYC  = (HICCUP_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RETRY_CYC       = RETRY_NS / CLK_PERIOD_NS;
	localparam int unsigned PG_DGL_CYC      = (PG_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TERM_DGL_CYC    = (TERM_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RECH_DGL_CYC    = (RECH_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BST_OL_CYC      = (BST_OL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BST_OFF_CYC     = (BST_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SOFTSTART_CYC   = (SOFTSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ADC_PERIOD_CYC  = (ADC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned DATA_W          = 8;
	localparam int unsigned ADDR_W          = 8;

	localparam logic [7:0] REG_CTRL0        = 8'h00;
	localparam logic [7:0] REG_CTRL1        = 8'h01;
	localparam logic [7:0] REG_CTRL2        = 8'h02;
	localparam logic [7:0] REG_CTRL3        = 8'h03;
	localparam logic [7:0] REG_CTRL4        = 8'h04;
	localparam logic [7:0] REG_STAT0        = 8'h05;
	localparam logic [7:0] REG_STAT1        = 8'h06;

	// control 0 bit positions
	localparam int unsigned C0_CHG_EN       = 0;
	localparam int unsigned C0_BST_EN       = 1;
	localparam int unsigned C0_STANDBY      = 2;
	localparam int unsigned C0_FB1          = 3;
	localparam int unsigned C0_FB2          = 4;
	localparam int unsigned C0_TRI_THR      = 5;
	// status 0 bit positions
	localparam int unsigned S0_PG           = 0;
	localparam int unsigned S0_CHG          = 1;
	localparam int unsigned S0_NTC_LO       = 2;
	localparam int unsigned S0_OL           = 5;
	localparam int unsigned S0_HIC          = 6;

	localparam logic [7:0] CTRL0_RST        = 8'h00;
	localparam logic [7:0] CTRL1_RST        = 8'h06;
	localparam logic [7:0] CTRL2_RST        = 8'h00;
	localparam logic [7:0] CTRL3_RST        = 8'h00;
	localparam logic [7:0] CTRL4_RST        = 8'h00;

	localparam logic [2:0] NTC_COLD         = 3'h0;
	localparam logic [2:0] NTC_COOL         = 3'h1;
	localparam logic [2:0] NTC_WARM         = 3'h2;
	localparam logic [2:0] NTC_STANDBY      = 3'h3;
	localparam logic [2:0] NTC_HOT          = 3'h4;

	typedef struct packed {
		logic vin_in_window;
		logic supply_above_por;
		logic rail_low;
		logic rail_above_bat;
		logic bat_below_tri;
		logic bat_at_cv;
		logic bat_above_rech;
		logic bat_below_rech;
		logic ichg_below_term;
		logic die_hot;
		logic rail_at_floor;
		logic boost_overload;
		logic target_above_bat;
		logic ld1_above_ld2;
		logic ntc_above0;
		logic ntc_above10;
		logic ntc_above45;
	} cpc_ana_t;

	typedef enum logic [1:0] {
		REF_BOOST_SET,
		REF_LOAD1,
		REF_LOAD2
	} cpc_ref_t;

	typedef struct packed {
		logic       input_switch_on;
		logic       high_side_on;
		logic       low_side_on;
		logic       charge_linear;
		logic       charge_switching;
		logic       charge_current_reduce;
		logic [1:0] trickle_current_sel;
		logic [4:0] cc_current_sel;
		logic [2:0] cv_voltage_sel;
		logic       trickle_threshold_sel;
		logic [1:0] termination_current_sel;
		logic       thermistor_bias;
		logic       boost_active;
		logic       boost_stepup;
		logic       boost_current_limit;
		logic       boost_softstart;
		logic [2:0] boost_voltage_sel;
		cpc_ref_t   rail_ref_sel;
		logic [1:0] rail_floor_sel;
		logic [1:0] regulator_voltage_sel;
		logic [4:0] switch_current_limit_sel;
		logic       adc_start;
	} cpc_ctl_t;

	typedef enum logic [2:0] {
		CHG_IDLE,
		CHG_TRICKLE,
		CHG_CC,
		CHG_CV_SW,
		CHG_CV_LIN,
		CHG_DONE
	} cpc_chg_t;

	typedef enum logic [1:0] {
		HIC_RUN,
		HIC_OFF,
		HIC_RETRY
	} cpc_hic_t;

	typedef enum logic [1:0] {
		BST_RUN,
		BST_OFF,
		BST_SOFT
	} cpc_bst_t;

endpackage

// File: hdl/cpc_deglitch.sv
/*
 * Continuous-level qualifier: output rises once the condition has held
 * for CYC consecutive clocks and falls with the condition. Assumes a
 * condition already synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
module cpc_deglitch #(
	parameter int unsigned W   = 24,
	parameter int unsigned CYC = 800
) (
	input  wire logic sys_clk_i,
	input  wire logic arst_n_i,
	input  wire logic cond_i,
	output logic      hit_o
);
	logic [W-1:0] cnt_ff;
	logic         hit_ff;

	// R26: restart on drop
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= '0;
			hit_ff <= 1'b0;
		end else if (!cond_i) begin
			cnt_ff <= '0;
			hit_ff <= 1'b0;
		end else if (cnt_ff == W'(CYC - 1)) begin
			hit_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + W'(1);
		end
	end

	assign hit_o = hit_ff;
endmodule

// File: hdl/cpc_top.sv
/*
 * Charge sequencer, rail short-circuit hiccup, boost overload hiccup,
 * feedback selection, battery level sampler and register port.
 * Assumes comparator results from the analog front end and a host that
 * performs one-cycle read / write strobes on the register port.
 */
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module cpc_top #(
	parameter int unsigned SCP_DETECT_CYC = cpc_pkg::SCP_DETECT_CYC,
	parameter int unsigned HICCUP_OFF_CYC = cpc_pkg::HICCUP_OFF_CYC,
	parameter int unsigned RETRY_CYC      = cpc_pkg::RETRY_CYC,
	parameter int unsigned PG_DGL_CYC     = cpc_pkg::PG_DGL_CYC,
	parameter int unsigned BST_OL_CYC     = cpc_pkg::BST_OL_CYC,
	parameter int unsigned BST_OFF_CYC    = cpc_pkg::BST_OFF_CYC,
	parameter int unsigned SOFTSTART_CYC  = cpc_pkg::SOFTSTART_CYC,
	parameter int unsigned ADC_PERIOD_CYC = cpc_pkg::ADC_PERIOD_CYC
) (
	input  wire logic                          sys_clk_i,
	input  wire logic                          arst_n_i,
	input  wire logic [cpc_pkg::ADDR_W-1:0]    reg_addr_i,
	input  wire logic [cpc_pkg::DATA_W-1:0]    reg_wdata_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	output logic      [cpc_pkg::DATA_W-1:0]    reg_rdata_o,
	input  wire cpc_pkg::cpc_ana_t             ana_i,
	input  wire logic [3:0]                    adc_code_i,
	input  wire logic                          adc_valid_i,
	output cpc_pkg::cpc_ctl_t                  ctl_o,
	output logic                               ntc_irq_o
);
	import cpc_pkg::*;

	localparam int unsigned AW = $bits(cpc_ana_t);

	logic [AW-1:0]    sync1_ff;
	logic [AW-1:0]    sync2_ff;
	cpc_ana_t         an;
	logic [7:0]       ctrl0_ff;
	logic [7:0]       ctrl1_ff;
	logic [7:0]       ctrl2_ff;
	logic [7:0]       ctrl3_ff;
	logic [7:0]       ctrl4_ff;
	logic [7:0]       rdata_ff;
	logic [7:0]       nxt_rdata;
	logic             ol_flag_ff;
	logic [3:0]       level_ff;
	logic             rail_low_hit;
	logic             pg_hit;
	logic             term_hit;
	logic             rech_hit;
	logic             ol_hit;
	logic             temp_ok;
	logic             allowed;
	logic             allowed_d_ff;
	logic             start_cycle;
	logic [2:0]       ntc_status;
	logic [2:0]       ntc_prev_ff;
	logic             ntc_irq_ff;
	cpc_chg_t         chg_ff;
	cpc_chg_t         nxt_chg;
	cpc_hic_t         hic_ff;
	logic [TMR_W-1:0] hic_cnt_ff;
	cpc_bst_t         bst_ff;
	logic [TMR_W-1:0] bst_cnt_ff;
	logic [TMR_W-1:0] adc_cnt_ff;
	logic             adc_start_ff;
	logic             charging;
	logic             hic_off;
	logic             boost_mode;
	logic             standby;
	cpc_ctl_t         ctl_ff;
	cpc_ctl_t         nxt_ctl;

	// R25: two-flop comparator sync
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= ana_i;
			sync2_ff <= sync1_ff;
		end
	end
	assign an = cpc_ana_t'(sync2_ff);

	// R23: power-good deglitch
	cpc_deglitch #(.W(TMR_W), .CYC(PG_DGL_CYC)) u_pg (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.cond_i    (an.vin_in_window),
		.hit_o     (pg_hit)
	);
	// R1: rail low for 1 ms
	cpc_deglitch #(.W(TMR_W), .CYC(SCP_DETECT_CYC)) u_scp (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.cond_i    (an.rail_low && pg_hit),
		.hit_o     (rail_low_hit)
	);
	// R8: termination-level deglitch
	cpc_deglitch #(.W(TMR_W), .CYC(TERM_DGL_CYC)) u_term (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.cond_i    (an.ichg_below_term),
		.hit_o     (term_hit)
	);
	// R10: recharge droop deglitch
	cpc_deglitch #(.W(TMR_W), .CYC(RECH_DGL_CYC)) u_rech (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.cond_i    (an.bat_below_rech && an.vin_in_window),
		.hit_o     (rech_hit)
	);
	// R21: overload lasting 1.2 ms
	cpc_deglitch #(.W(TMR_W), .CYC(BST_OL_CYC)) u_ol (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.cond_i    (an.boost_overload && bst_ff == BST_RUN && boost_mode),
		.hit_o     (ol_hit)
	);

	// R24: registers to defaults
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl0_ff <= CTRL0_RST;
			ctrl1_ff <= CTRL1_RST;
			ctrl2_ff <= CTRL2_RST;
			ctrl3_ff <= CTRL3_RST;
			ctrl4_ff <= CTRL4_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CTRL0: ctrl0_ff <= reg_wdata_i;
				REG_CTRL1: ctrl1_ff <= reg_wdata_i;
				REG_CTRL2: ctrl2_ff <= reg_wdata_i;
				REG_CTRL3: ctrl3_ff <= reg_wdata_i;
				REG_CTRL4: ctrl4_ff <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	assign standby = ctrl0_ff[C0_STANDBY];

	// R12: standby forces 011
	always_comb begin
		if (standby)
			ntc_status = NTC_STANDBY;
		else if (an.ntc_above45)
			ntc_status = NTC_HOT;
		else if (an.ntc_above10)
			ntc_status = NTC_WARM;
		else if (an.ntc_above0)
			ntc_status = NTC_COOL;
		else
			ntc_status = NTC_COLD;
	end

	// no detection in standby, so the window cannot block charging
	assign temp_ok = standby || (an.ntc_above0 && !an.ntc_above45);

	// R4: all three conditions
	assign allowed     = pg_hit && ctrl0_ff[C0_CHG_EN] && temp_ok;
	// R15: enable rise restarts
	assign start_cycle = allowed && !allowed_d_ff;
	assign charging    = chg_ff != CHG_IDLE && chg_ff != CHG_DONE;

	// R13: crossing pulses
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ntc_prev_ff  <= NTC_COLD;
			ntc_irq_ff   <= 1'b0;
			allowed_d_ff <= 1'b0;
		end else begin
			ntc_prev_ff  <= ntc_status;
			ntc_irq_ff   <= charging && !standby && ntc_status != ntc_prev_ff;
			allowed_d_ff <= allowed;
		end
	end

	always_comb begin
		nxt_chg = chg_ff;
		case (chg_ff)
			CHG_IDLE: begin
				// R5: trickle or switching start
				if (start_cycle)
					nxt_chg = an.bat_below_tri ? CHG_TRICKLE : (an.bat_at_cv ? CHG_CV_SW : CHG_CC);
			end
			CHG_TRICKLE: begin
				// R6: leave trickle for cc
				if (!an.bat_below_tri)
					nxt_chg = CHG_CC;
			end
			CHG_CC: begin
				// R7: cv threshold reached
				if (an.bat_at_cv)
					nxt_chg = CHG_CV_SW;
			end
			CHG_CV_SW: begin
				// R9: immediate termination
				if (an.bat_above_rech && an.ichg_below_term)
					nxt_chg = CHG_DONE;
				// R8: switch to linear
				else if (term_hit)
					nxt_chg = CHG_CV_LIN;
			end
			CHG_CV_LIN: begin
				if (an.bat_above_rech && an.ichg_below_term)
					nxt_chg = CHG_DONE;
			end
			CHG_DONE: begin
				// R10: recharge in switching
				if (rech_hit)
					nxt_chg = CHG_CC;
			end
			default: nxt_chg = CHG_IDLE;
		endcase
		// R13: out of window terminates
		if (!allowed)
			nxt_chg = CHG_IDLE;
	end

	// R25: one phase at a time
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			chg_ff <= CHG_IDLE;
		else
			chg_ff <= nxt_chg;
	end

	// R2: off 36 ms, retry 1 ms
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hic_ff     <= HIC_RUN;
			hic_cnt_ff <= '0;
		end else begin
			case (hic_ff)
				HIC_RUN: begin
					hic_cnt_ff <= '0;
					// R1: enter hiccup
					if (rail_low_hit)
						hic_ff <= HIC_OFF;
				end
				HIC_OFF: begin
					if (hic_cnt_ff == TMR_W'(HICCUP_OFF_CYC - 1)) begin
						hic_cnt_ff <= '0;
						hic_ff     <= HIC_RETRY;
					end else begin
						hic_cnt_ff <= hic_cnt_ff + TMR_W'(1);
					end
				end
				HIC_RETRY: begin
					if (!an.rail_low) begin
						hic_ff <= HIC_RUN;
					end else if (hic_cnt_ff == TMR_W'(RETRY_CYC - 1)) begin
						hic_cnt_ff <= '0;
						hic_ff     <= HIC_OFF;
					end else begin
						hic_cnt_ff <= hic_cnt_ff + TMR_W'(1);
					end
				end
				default: hic_ff <= HIC_RUN;
			endcase
		end
	end
	assign hic_off = hic_ff == HIC_OFF;

	// R18: input lost, boost from battery
	assign boost_mode = ctrl0_ff[C0_BST_EN] && !an.vin_in_window;

	// R21: overload shutdown and restart
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bst_ff     <= BST_RUN;
			bst_cnt_ff <= '0;
		end else begin
			case (bst_ff)
				BST_RUN: begin
					bst_cnt_ff <= '0;
					if (ol_hit)
						bst_ff <= BST_OFF;
				end
				BST_OFF: begin
					if (bst_cnt_ff == TMR_W'(BST_OFF_CYC - 1)) begin
						bst_cnt_ff <= '0;
						bst_ff     <= BST_SOFT;
					end else begin
						bst_cnt_ff <= bst_cnt_ff + TMR_W'(1);
					end
				end
				BST_SOFT: begin
					if (bst_cnt_ff == TMR_W'(SOFTSTART_CYC - 1)) begin
						bst_cnt_ff <= '0;
						bst_ff     <= BST_RUN;
					end else begin
						bst_cnt_ff <= bst_cnt_ff + TMR_W'(1);
					end
				end
				default: bst_ff <= BST_RUN;
			endcase
		end
	end

	// R14: 100 ms battery sampling
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			adc_cnt_ff   <= '0;
			adc_start_ff <= 1'b0;
			level_ff     <= 4'h0;
		end else begin
			adc_start_ff <= 1'b0;
			if (!an.supply_above_por) begin
				adc_cnt_ff <= '0;
			end else if (adc_cnt_ff == TMR_W'(ADC_PERIOD_CYC - 1)) begin
				adc_cnt_ff   <= '0;
				adc_start_ff <= 1'b1;
			end else begin
				adc_cnt_ff <= adc_cnt_ff + TMR_W'(1);
			end
			if (adc_valid_i)
				level_ff <= adc_code_i;
		end
	end

	// overload flag: set wins over the read that clears it
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ol_flag_ff <= 1'b0;
		else if (bst_ff == BST_RUN && ol_hit)
			ol_flag_ff <= 1'b1;
		else if (reg_rd_i && reg_addr_i == REG_STAT0)
			ol_flag_ff <= 1'b0;
	end

	always_comb begin
		nxt_ctl = '0;
		// R3: buck only above battery
		nxt_ctl.charge_switching = !hic_off && an.rail_above_bat &&
			(chg_ff == CHG_CC || chg_ff == CHG_CV_SW);
		nxt_ctl.charge_linear = !hic_off && an.rail_above_bat &&
			(chg_ff == CHG_TRICKLE || chg_ff == CHG_CV_LIN);
		// R11: thermal foldback
		// R17: rail floor foldback
		nxt_ctl.charge_current_reduce   = charging && (an.die_hot || an.rail_at_floor);
		nxt_ctl.trickle_current_sel     = ctrl2_ff[4:3];
		nxt_ctl.cc_current_sel          = ctrl1_ff[4:0];
		nxt_ctl.cv_voltage_sel          = ctrl2_ff[2:0];
		nxt_ctl.trickle_threshold_sel   = ctrl0_ff[C0_TRI_THR];
		nxt_ctl.termination_current_sel = ctrl2_ff[6:5];
		nxt_ctl.thermistor_bias         = !standby;
		// R2: all switches off in the hiccup off phase
		nxt_ctl.input_switch_on         = an.vin_in_window && !hic_off;
		nxt_ctl.boost_active            = boost_mode && bst_ff != BST_OFF && !hic_off;
		// R19: step-up versus bypass
		nxt_ctl.boost_stepup            = nxt_ctl.boost_active && an.target_above_bat;
		nxt_ctl.boost_current_limit     = boost_mode && an.boost_overload;
		nxt_ctl.boost_softstart         = boost_mode && bst_ff == BST_SOFT;
		nxt_ctl.boost_voltage_sel       = ctrl3_ff[2:0];
		nxt_ctl.high_side_on            = nxt_ctl.charge_switching || nxt_ctl.boost_active;
		nxt_ctl.low_side_on             = nxt_ctl.charge_switching || nxt_ctl.boost_stepup;
		// R20: higher connected feedback
		case ({ctrl0_ff[C0_FB2], ctrl0_ff[C0_FB1]})
			2'h1:    nxt_ctl.rail_ref_sel = REF_LOAD1;
			2'h2:    nxt_ctl.rail_ref_sel = REF_LOAD2;
			2'h3:    nxt_ctl.rail_ref_sel = an.ld1_above_ld2 ? REF_LOAD1 : REF_LOAD2;
			default: nxt_ctl.rail_ref_sel = REF_BOOST_SET;
		endcase
		nxt_ctl.rail_floor_sel          = ctrl3_ff[4:3];
		nxt_ctl.regulator_voltage_sel   = ctrl3_ff[6:5];
		// R22: load current limit field
		nxt_ctl.switch_current_limit_sel = ctrl4_ff[4:0];
		nxt_ctl.adc_start               = adc_start_ff;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ctl_ff <= '0;
		else
			ctl_ff <= nxt_ctl;
	end

	always_comb begin
		nxt_rdata = 8'h00;
		case (reg_addr_i)
			REG_CTRL0: nxt_rdata = ctrl0_ff;
			REG_CTRL1: nxt_rdata = ctrl1_ff;
			REG_CTRL2: nxt_rdata = ctrl2_ff;
			REG_CTRL3: nxt_rdata = ctrl3_ff;
			REG_CTRL4: nxt_rdata = ctrl4_ff;
			REG_STAT0: begin
				nxt_rdata[S0_PG]               = pg_hit;
				// R9: charging flag clears
				nxt_rdata[S0_CHG]              = charging;
				nxt_rdata[S0_NTC_LO +: 3]      = ntc_status;
				nxt_rdata[S0_OL]               = ol_flag_ff;
				nxt_rdata[S0_HIC]              = hic_ff != HIC_RUN;
			end
			REG_STAT1: nxt_rdata = {1'b0, chg_ff, level_ff};
			default:   nxt_rdata = 8'h00;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdata_ff <= 8'h00;
		else if (reg_rd_i)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= 8'h00;
	end

	assign reg_rdata_o = rdata_ff;
	assign ctl_o       = ctl_ff;
	assign ntc_irq_o   = ntc_irq_ff;
endmodule

// File: verif/cpc_sva.sv
/* port assertions for cpc_top.
 * assumes supply_above_por held high by the bench. */
`timescale 1ns/1ps
module cpc_sva
	import cpc_pkg::*;
#(
	parameter int unsigned ADC_PERIOD_CYC = 40
) (
	input wire logic        sys_clk_i,
	input wire logic        arst_n_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire cpc_ana_t    ana_i,
	input wire logic [3:0]  adc_code_i,
	input wire logic        adc_valid_i,
	input wire cpc_ctl_t    ctl_o,
	input wire logic        ntc_irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	wire charging_flag = ctl_o.charge_linear | ctl_o.charge_switching;
	wire c0  = reg_wr_i && reg_addr_i == REG_CTRL0;

	chk_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read cycle");
	chk_irq_single: assert property (ntc_irq_o |=> !ntc_irq_o)
		else $error("irq longer than one cycle");
	chk_adc_gap: assert property (ctl_o.adc_start |=> !ctl_o.adc_start [*8])
		else $error("adc start too soon");
	chk_adc_period: assert property (ctl_o.adc_start |-> ##ADC_PERIOD_CYC ctl_o.adc_start)
		else $error("adc start period wrong");
	chk_standby_bias: assert property (c0 && reg_wdata_i[C0_STANDBY] |-> ##[1:3] !ctl_o.thermistor_bias)
		else $error("bias on in standby");
	chk_enable_stop: assert property (c0 && !reg_wdata_i[C0_CHG_EN] |-> ##[1:4] !charging_flag)
		else $error("charging after disable");
	chk_input_loss: assert property (!ana_i.vin_in_window [*8] |-> !charging_flag)
		else $error("charging without input");
	chk_ref_boost: assert property (c0 && reg_wdata_i[4:3] == 2'h0 |-> ##[1:3] ctl_o.rail_ref_sel == REF_BOOST_SET)
		else $error("rail ref not boost setting");
endmodule

bind cpc_top cpc_sva #(.ADC_PERIOD_CYC(ADC_PERIOD_CYC)) u_sva (
	.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ana_i(ana_i),
	.adc_code_i(adc_code_i), .adc_valid_i(adc_valid_i), .ctl_o(ctl_o), .ntc_irq_o(ntc_irq_o));

// File: verif/cpc_host.sv
/* host side of the register port, driven through tasks.
 * assumes read data in the cycle after the strobe. */
`timescale 1ns/1ps
module cpc_host (
	input  wire logic [cpc_pkg::DATA_W-1:0] rdata_i,
	input  wire logic                       sys_clk_i,
	output logic      [cpc_pkg::ADDR_W-1:0] addr_o,
	output logic      [cpc_pkg::DATA_W-1:0] wdata_o,
	output logic                            wr_o,
	output logic                            rd_o
);
	import cpc_pkg::*;
	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
	endtask
	// data stand only in the cycle after the taking edge, so take them at the next edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		@(posedge sys_clk_i);
		d = rdata_i;
	endtask
endmodule

// File: verif/tb.sv
/* self-checking bench for cpc_top with shortened intervals.
 * assumes the host model for register access. */
`timescale 1ns/1ps
module tb;
	import cpc_pkg::*;
	logic       sys_clk_i, arst_n_i, wr, rd, irq, adc_valid;
	logic [3:0] adc_code;
	logic [7:0] addr, wdata, rdata, d;
	cpc_ana_t   ana;
	cpc_ctl_t   ctl;
	int         miscompares = 0;
	int         comparisons = 0;
	int         irqs = 0;
	logic [7:0] rst_v [5] = '{CTRL0_RST, CTRL1_RST, CTRL2_RST, CTRL3_RST, CTRL4_RST};

	cpc_top #(.SCP_DETECT_CYC(20), .HICCUP_OFF_CYC(50), .PG_DGL_CYC(30), .BST_OL_CYC(20),
		.ADC_PERIOD_CYC(40)) DUT (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .ana_i(ana), .adc_code_i(adc_code), .adc_valid_i(adc_valid),
		.ctl_o(ctl), .ntc_irq_o(irq));
	cpc_host host (.rdata_i(rdata), .sys_clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) if (irq === 1'b1) irqs++;

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rchk(input string s, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		host.rd(a, d);
		chk(s, e, d & m);
	endtask
	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic t_reset;
		for (int i = 0; i < 5; i++) rchk("ctrl", 8'(i), 8'hFF, rst_v[i]);
		rchk("unmapped", 8'h20, 8'hFF, 8'h00);
		host.wr(REG_STAT1, 8'hFF);
		rchk("stat1 ro", REG_STAT1, 8'h70, 8'h00);
		host.wr(REG_CTRL4, 8'h15);
		cyc(2);
		chk("load ilim", 8'h15, 8'(ctl.switch_current_limit_sel));
		chk("bias", 8'h01, 8'(ctl.thermistor_bias));
		$display("t_reset done");
	endtask
	task automatic t_pg;
		ana.vin_in_window <= 1'b1;
		cyc(26);
		rchk("pg early", REG_STAT0, 8'h01, 8'h00);
		cyc(10);
		rchk("pg", REG_STAT0, 8'h01, 8'h01);
		$display("t_pg done");
	endtask
	task automatic t_charge;
		host.wr(REG_CTRL0, 8'h01);
		cyc(6);
		rchk("trickle", REG_STAT1, 8'h70, 8'h10);
		chk("linear", 8'h01, 8'(ctl.charge_linear));
		ana.bat_below_tri <= 1'b0;
		ana.die_hot <= 1'b1;
		cyc(6);
		rchk("cc", REG_STAT1, 8'h70, 8'h20);
		chk("switching", 8'h01, 8'(ctl.charge_switching));
		chk("hot reduce", 8'h01, 8'(ctl.charge_current_reduce));
		ana.die_hot <= 1'b0;
		ana.rail_at_floor <= 1'b1;
		ana.rail_above_bat <= 1'b0;
		cyc(6);
		chk("floor reduce", 8'h01, 8'(ctl.charge_current_reduce));
		chk("buck gate", 8'h00, 8'(ctl.charge_switching));
		ana.rail_above_bat <= 1'b1;
		ana.rail_at_floor <= 1'b0;
		ana.bat_at_cv <= 1'b1;
		ana.ichg_below_term <= 1'b1;
		cyc(6);
		rchk("cv sw", REG_STAT1, 8'h70, 8'h30);
		cyc(800);
		rchk("cv lin", REG_STAT1, 8'h70, 8'h40);
		ana.bat_above_rech <= 1'b1;
		cyc(5);
		rchk("done", REG_STAT1, 8'h70, 8'h50);
		rchk("chg flag", REG_STAT0, 8'h02, 8'h00);
		ana.bat_above_rech <= 1'b0;
		ana.bat_at_cv <= 1'b0;
		ana.ichg_below_term <= 1'b0;
		ana.bat_below_rech <= 1'b1;
		cyc(2520);
		rchk("recharge", REG_STAT1, 8'h70, 8'h20);
		ana.ntc_above45 <= 1'b1;
		cyc(6);
		rchk("hot stop", REG_STAT1, 8'h70, 8'h00);
		chk("irq", 8'h01, 8'(irqs > 0));
		ana.ntc_above45 <= 1'b0;
		cyc(6);
		rchk("restart", REG_STAT1, 8'h70, 8'h20);
		host.wr(REG_CTRL0, 8'h00);
		cyc(4);
		rchk("disable", REG_STAT1, 8'h70, 8'h00);
		$display("t_charge done");
	endtask
	task automatic t_hiccup;
		ana.rail_low <= 1'b1;
		cyc(30);
		rchk("hiccup", REG_STAT0, 8'h40, 8'h40);
		chk("sw off", 8'h00, 8'({ctl.input_switch_on, ctl.high_side_on, ctl.low_side_on}));
		ana.rail_low <= 1'b0;
		cyc(120);
		rchk("hiccup end", REG_STAT0, 8'h40, 8'h00);
		$display("t_hiccup done");
	endtask
	task automatic t_misc;
		adc_code <= 4'hA;
		adc_valid <= 1'b1;
		cyc(1);
		adc_valid <= 1'b0;
		cyc(3);
		rchk("level", REG_STAT1, 8'h0F, 8'h0A);
		host.wr(REG_CTRL0, 8'h0C);
		cyc(4);
		rchk("standby", REG_STAT0, 8'h1C, 8'h0C);
		chk("ref", 8'(REF_LOAD1), 8'(ctl.rail_ref_sel));
		host.wr(REG_CTRL0, 8'h02);
		ana.vin_in_window <= 1'b0;
		ana.target_above_bat <= 1'b1;
		cyc(6);
		chk("boost", 8'h01, 8'(ctl.boost_active));
		chk("stepup", 8'h01, 8'(ctl.boost_stepup));
		ana.boost_overload <= 1'b1;
		cyc(30);
		chk("boost off", 8'h00, 8'(ctl.boost_active));
		ana.boost_overload <= 1'b0;
		rchk("ol", REG_STAT0, 8'h20, 8'h20);
		rchk("ol clear", REG_STAT0, 8'h20, 8'h00);
		$display("t_misc done");
	endtask

	initial begin
		arst_n_i = 1'b0;
		adc_valid = 1'b0;
		adc_code = 4'h0;
		ana = '0;
		ana.supply_above_por = 1'b1;
		ana.rail_above_bat = 1'b1;
		ana.bat_below_tri = 1'b1;
		ana.ntc_above0 = 1'b1;
		ana.ntc_above10 = 1'b1;
		cyc(5);
		arst_n_i <= 1'b1;
		t_reset();
		t_pg();
		t_charge();
		t_hiccup();
		t_misc();
		end_sim();
	end
	// hang guard
	initial begin
		cyc(20000);
		miscompares++;
		end_sim();
	end
endmodule
